//--- design/hfcw_pkg.sv
/*
 * hfcw_pkg: shared constants for the hyperframe control word access block.
 * Assumes: both ends refer to it by hfcw_pkg::name; the carrier interface does not use it.
 */
package hfcw_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_WORDS    = 256;
    localparam int unsigned IDX_W        = 8;
    localparam int unsigned SEQ_W        = 4;
    localparam int unsigned NUM_SEQ      = 12;
    localparam int unsigned CW_BYTES     = 48;
    localparam int unsigned CW_W         = 384;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned RATE_W       = 4;
    localparam int unsigned CMD_W        = 2;

    // ----------------------------------------------------------------
    // line rate codes
    // ----------------------------------------------------------------
    localparam logic [3:0] RATE_0P6  = 4'h0;
    localparam logic [3:0] RATE_1P2  = 4'h1;
    localparam logic [3:0] RATE_2P4  = 4'h2;
    localparam logic [3:0] RATE_3P0  = 4'h3;
    localparam logic [3:0] RATE_4P9  = 4'h4;
    localparam logic [3:0] RATE_6P1  = 4'h5;
    localparam logic [3:0] RATE_8P1  = 4'h6;
    localparam logic [3:0] RATE_9P8  = 4'h7;
    localparam logic [3:0] RATE_10P1 = 4'h8;
    localparam logic [3:0] RATE_12P1 = 4'h9;
    localparam logic [3:0] RATE_24P3 = 4'hA;

    // ----------------------------------------------------------------
    // link command codes from controller to device
    // ----------------------------------------------------------------
    localparam logic [1:0] CMD_NONE   = 2'h0;
    localparam logic [1:0] CMD_RX_SEL = 2'h1;
    localparam logic [1:0] CMD_TX_SEL = 2'h2;
    localparam logic [1:0] CMD_TX_WR  = 2'h3;

    // ----------------------------------------------------------------
    // controller register map (ahb byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_RATE    = 8'h00;
    localparam logic [7:0] A_RX_SEL  = 8'h04;
    localparam logic [7:0] A_TX_SEL  = 8'h08;
    localparam logic [7:0] A_TX_DATA = 8'h0C;
    localparam logic [7:0] A_RX_DATA = 8'h10;
    localparam logic [7:0] A_STATUS  = 8'h14;
    // select word: index in [7:0], section in [11:8]
    localparam int unsigned SEL_IDX_LSB = 0;
    localparam int unsigned SEL_SEQ_LSB = 8;

    // number of populated bytes in section seq at a given rate
    function automatic logic [2:0] sect_bytes(input logic [3:0] rate, input logic [3:0] seq);
        logic [5:0] total;
        logic [5:0] base;
        total = 6'h00;
        base  = {seq, 2'b00};
        case (rate)
            RATE_0P6:  total = 6'h01;
            RATE_1P2:  total = 6'h02;
            RATE_2P4:  total = 6'h04;
            RATE_3P0:  total = 6'h05;
            RATE_4P9:  total = 6'h08;
            RATE_6P1:  total = 6'h0A;
            RATE_8P1:  total = 6'h10;
            RATE_9P8:  total = 6'h10;
            RATE_10P1: total = 6'h11;
            RATE_12P1: total = 6'h18;
            RATE_24P3: total = 6'h30;
            default:   total = 6'h00;
        endcase
        if (total <= base)
            return 3'h0;
        else if (total - base >= 6'h04)
            return 3'h4;
        else
            return 3'(total - base);
    endfunction
endpackage

//--- design/hfcw_if.sv
/*
 * hfcw_if: carrier between controller end and device end.
 * Assumes: both ends on hclk; controller drives commands, device drives read slice.
 */
`timescale 1ns/1ps
`default_nettype none
interface hfcw_if (
    input wire logic hclk
);
    logic [1:0]  cmd;
    logic [7:0]  cmd_idx;
    logic [3:0]  cmd_seq;
    logic [31:0] cmd_data;
    logic [3:0]  rate;
    logic [31:0] rx_slice;

    modport dev (
        input  cmd,
        input  cmd_idx,
        input  cmd_seq,
        input  cmd_data,
        input  rate,
        output rx_slice
    );
    modport ctl (
        output cmd,
        output cmd_idx,
        output cmd_seq,
        output cmd_data,
        output rate,
        input  rx_slice
    );
endinterface
`default_nettype wire

//--- design/hfcw_dev.sv
/*
 * hfcw_dev: device end; receive and transmit control word tables with
 * rate dependent 32-bit section windows.
 * Assumes: commands arrive one per cycle on hclk; received words arrive on
 * the user side as whole 384-bit words with a write strobe.
 */
// Behaviour
// - each access moves exactly 32 bits
// - section number selects a 32-bit slice
// - unpopulated nibbles read zero, writes leave them unchanged
// - lowest rate byte in bits 31:24
// - 1.2288 bytes zero, one in upper half
// - section population follows line rate
// - 3.072 packs four bytes, then one
// - same packing for receive and transmit
// - receive table holds last word per index
// - host selects index, device returns content
// - host index is subchannel plus 64*position
// - section zero valid next clock cycle
// - host steps sections by rate
// - 10.1376 section four holds vendor bytes
// - access path exists only when enabled
// - select fields hold addressed word index
`timescale 1ns/1ps
`default_nettype none
module hfcw_dev #(
    parameter bit ENABLE_CW_ACCESS = 1'b1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    hfcw_if.dev               link,
    input  wire logic         rx_we,
    input  wire logic [7:0]   rx_widx,
    input  wire logic [383:0] rx_wdata,
    input  wire logic [7:0]   tx_ridx,
    output logic      [383:0] tx_rdata,
    output logic      [7:0]   rx_idx_q,
    output logic      [3:0]   rx_seq_q,
    output logic      [7:0]   tx_idx_q,
    output logic      [3:0]   tx_seq_q
);
    // ----------------------------------------------------------------
    // tables
    // ----------------------------------------------------------------
    // byte lanes of one register slice; lane 0 is the top byte
    localparam int unsigned LANES   = hfcw_pkg::DATA_W / 8;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned LANE_HI = hfcw_pkg::DATA_W - 1;
    localparam int unsigned WORD_HI = hfcw_pkg::CW_W - 1;
    localparam logic [3:0]  SEQ_END = 4'(hfcw_pkg::NUM_SEQ);

    logic [hfcw_pkg::CW_W-1:0]   rx_tab [0:hfcw_pkg::NUM_WORDS-1];
    logic [hfcw_pkg::CW_W-1:0]   tx_tab [0:hfcw_pkg::NUM_WORDS-1];
    logic [2:0]                  tx_nb;
    logic [2:0]                  rx_nb;
    logic [LANES-1:0]            tx_lane_en;
    logic [LANES-1:0]            rx_lane_en;
    logic [hfcw_pkg::DATA_W-1:0] rx_raw;
    logic [hfcw_pkg::DATA_W-1:0] rx_slice_d;
    logic [8:0]                  rx_top;
    logic [8:0]                  tx_top;
    logic                        rx_sel_hit;
    logic                        tx_sel_hit;
    logic                        tx_wr_hit;
    logic                        rx_seq_ok;
    logic                        tx_seq_ok;

    // ----------------------------------------------------------------
    // command decode; with the option off every command is dropped
    // ----------------------------------------------------------------
    assign rx_sel_hit = ENABLE_CW_ACCESS && (link.cmd == hfcw_pkg::CMD_RX_SEL);
    assign tx_sel_hit = ENABLE_CW_ACCESS && (link.cmd == hfcw_pkg::CMD_TX_SEL);
    assign tx_wr_hit  = ENABLE_CW_ACCESS && (link.cmd == hfcw_pkg::CMD_TX_WR) && tx_seq_ok;
    assign rx_seq_ok  = rx_seq_q < SEQ_END;
    assign tx_seq_ok  = tx_seq_q < SEQ_END;

    // ----------------------------------------------------------------
    // section population
    // ----------------------------------------------------------------
    assign tx_nb = hfcw_pkg::sect_bytes(link.rate, tx_seq_q);
    assign rx_nb = hfcw_pkg::sect_bytes(link.rate, rx_seq_q);
    // top bit of the section inside the word; only used while the section is in range
    assign rx_top = 9'(WORD_HI - hfcw_pkg::DATA_W * rx_seq_q);
    assign tx_top = 9'(WORD_HI - hfcw_pkg::DATA_W * tx_seq_q);

    // byte 0 of a section sits in [31:24]; big-end packing of the word
    for (genvar b = 0; b < LANES; b++) begin : g_lane
        assign tx_lane_en[b] = 3'(b) < tx_nb;
        assign rx_lane_en[b] = 3'(b) < rx_nb;
    end

    // ----------------------------------------------------------------
    // select fields
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_idx_q <= 8'h00;
        end else if (rx_sel_hit) begin
            rx_idx_q <= link.cmd_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_seq_q <= 4'h0;
        end else if (rx_sel_hit) begin
            rx_seq_q <= link.cmd_seq;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_idx_q <= 8'h00;
        end else if (tx_sel_hit) begin
            tx_idx_q <= link.cmd_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_seq_q <= 4'h0;
        end else if (tx_sel_hit) begin
            tx_seq_q <= link.cmd_seq;
        end
    end

    // ----------------------------------------------------------------
    // table writes
    // ----------------------------------------------------------------
    always_ff @(posedge hclk) begin
        if (rx_we) begin
            rx_tab[rx_widx] <= rx_wdata;
        end
    end

    // only the populated bytes of the section are touched, so other
    // sections of the word keep their contents
    always_ff @(posedge hclk) begin
        if (tx_wr_hit) begin
            for (int b = 0; b < LANES; b++) begin
                if (tx_lane_en[b]) begin
                    tx_tab[tx_idx_q][tx_top-BYTE_W*b -: BYTE_W] <= link.cmd_data[LANE_HI-BYTE_W*b -: BYTE_W];
                end
            end
        end
    end

    // transmit table read port is registered, one cycle behind tx_ridx
    always_ff @(posedge hclk) begin
        tx_rdata <= tx_tab[tx_ridx];
    end

    // ----------------------------------------------------------------
    // receive slice; valid the cycle after select
    // ----------------------------------------------------------------
    // unpopulated lanes never read the table, so unwritten bytes cannot leak
    always_comb begin
        rx_raw = 32'h0000_0000;
        rx_slice_d = 32'h0000_0000;
        for (int b = 0; b < LANES; b++) begin
            if (rx_seq_ok && rx_lane_en[b]) begin
                rx_raw[LANE_HI-BYTE_W*b -: BYTE_W] = rx_tab[rx_idx_q][rx_top-BYTE_W*b -: BYTE_W];
            end
        end
        rx_slice_d = rx_raw;
    end

    // combinational read path keeps the slice valid the cycle after select;
    // reads never write back to any state
    assign link.rx_slice = ENABLE_CW_ACCESS ? rx_slice_d : 32'h0000_0000;
endmodule // hfcw_dev
`default_nettype wire

//--- design/hfcw_ctl.sv
/*
 * hfcw_ctl: controller end; ahb-lite slave whose registers drive the link.
 * Assumes: single word transfers, one ahb master, device end on same hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module hfcw_ctl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    hfcw_if.ctl              link
);
    // ----------------------------------------------------------------
    // address phase capture
    // ----------------------------------------------------------------
    logic       wr_q;
    logic       rd_q;
    logic [7:0] addr_q;
    logic [3:0] rate_q;
    logic [11:0] rx_sel_q;
    logic [11:0] tx_sel_q;
    logic       go;

    assign go = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q   <= go && hwrite;
            rd_q   <= go && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_q   <= hfcw_pkg::RATE_0P6;
            rx_sel_q <= 12'h000;
            tx_sel_q <= 12'h000;
        end else if (wr_q) begin
            case (addr_q)
                hfcw_pkg::A_RATE:   rate_q   <= hwdata[3:0];
                hfcw_pkg::A_RX_SEL: rx_sel_q <= hwdata[11:0];
                hfcw_pkg::A_TX_SEL: tx_sel_q <= hwdata[11:0];
                default: ;
            endcase
        end
    end

    // write to a select or transmit data register becomes a link command
    always_comb begin
        link.cmd = hfcw_pkg::CMD_NONE;
        if (wr_q) begin
            case (addr_q)
                hfcw_pkg::A_RX_SEL:  link.cmd = hfcw_pkg::CMD_RX_SEL;
                hfcw_pkg::A_TX_SEL:  link.cmd = hfcw_pkg::CMD_TX_SEL;
                hfcw_pkg::A_TX_DATA: link.cmd = hfcw_pkg::CMD_TX_WR;
                default:             link.cmd = hfcw_pkg::CMD_NONE;
            endcase
        end
    end

    assign link.cmd_idx  = hwdata[7:0];
    assign link.cmd_seq  = hwdata[11:8];
    assign link.cmd_data = hwdata;
    assign link.rate     = rate_q;

    // ----------------------------------------------------------------
    // read mux; unmapped reads as zero, always okay, no wait states
    // ----------------------------------------------------------------
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_q) begin
            case (addr_q)
                hfcw_pkg::A_RATE:    hrdata = {28'h0000000, rate_q};
                hfcw_pkg::A_RX_SEL:  hrdata = {20'h00000, rx_sel_q};
                hfcw_pkg::A_TX_SEL:  hrdata = {20'h00000, tx_sel_q};
                hfcw_pkg::A_RX_DATA: hrdata = link.rx_slice;
                default:             hrdata = 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
endmodule // hfcw_ctl
`default_nettype wire

//--- dv/hfcw_properties.sv
/*
 * hfcw_chk: link-side checks of slice packing by rate and section.
 * Assumes: instantiated beside the link interface, one hclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module hfcw_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [1:0]  cmd,
    input wire logic [3:0]  cmd_seq,
    input wire logic [3:0]  rate,
    input wire logic [31:0] rx_slice
);
    // ----------------------------------------------------------------
    // receive section mirror, taken with the select pulse
    // ----------------------------------------------------------------
    logic [3:0] seq_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) seq_q <= 4'h0;
        else if (cmd == hfcw_pkg::CMD_RX_SEL) seq_q <= cmd_seq;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_SEQ_BEYOND: assert property (cmd == hfcw_pkg::CMD_RX_SEL && cmd_seq >= 4'hC |=> rx_slice == 32'h0)
        else $error("slice not zero past last section");
    AST_LOW_RATE: assert property (rate == hfcw_pkg::RATE_0P6 |-> rx_slice[23:0] == 24'h0 && (seq_q == 4'h0 || rx_slice == 32'h0))
        else $error("lowest rate slice packing wrong");
    AST_RATE1_HALF: assert property (rate == hfcw_pkg::RATE_1P2 |-> rx_slice[15:0] == 16'h0)
        else $error("lower half not zero at second rate");
    AST_RATE2_ONE: assert property (rate == hfcw_pkg::RATE_2P4 && seq_q != 4'h0 |-> rx_slice == 32'h0)
        else $error("extra section populated at third rate");
    AST_RATE3_TOP: assert property (rate == hfcw_pkg::RATE_3P0 && seq_q == 4'h1 |-> rx_slice[23:0] == 24'h0)
        else $error("second section holds more than one byte");
    AST_RATE5_HALF: assert property (rate == hfcw_pkg::RATE_6P1 && seq_q == 4'h2 |-> rx_slice[15:0] == 16'h0)
        else $error("unpopulated nibbles not zero");
    AST_VENDOR_BYTE: assert property (rate == hfcw_pkg::RATE_10P1 && seq_q == 4'h4 |-> rx_slice[23:0] == 24'h0)
        else $error("vendor section wider than one byte");
    AST_RATE9_END: assert property (rate == hfcw_pkg::RATE_12P1 && seq_q >= 4'h6 |-> rx_slice == 32'h0)
        else $error("section beyond six populated");
    cover property (cmd == hfcw_pkg::CMD_RX_SEL);
    cover property (rate == hfcw_pkg::RATE_24P3 && seq_q == 4'hB);
    cover property (cmd == hfcw_pkg::CMD_TX_WR);
endmodule // hfcw_chk
`default_nettype wire

//--- dv/test_hyperframe_ctrl_word_access.sv
/*
 * test_hyperframe_ctrl_word_access: ahb-lite bench for both ends.
 * Assumes: zero wait state slave, receive table filled from the user side.
 */
`timescale 1ns/1ps
`default_nettype none
module test_hyperframe_ctrl_word_access;
    logic hclk, hresetn, hsel, hwrite, rx_we, hready, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] rx_widx, tx_ridx, rx_idx_q, tx_idx_q, x;
    logic [3:0] rx_seq_q, tx_seq_q;
    logic [383:0] rx_wdata, tx_rdata;
    int bad_count, num_checks;
    localparam int POP[11] = '{1, 2, 4, 5, 8, 10, 16, 16, 17, 24, 48};
    hfcw_if u_hfcw_if (.hclk(hclk));
    hfcw_ctl u_hfcw_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .link(u_hfcw_if.ctl));
    hfcw_dev u_hfcw_dev (.hclk(hclk), .hresetn(hresetn), .link(u_hfcw_if.dev), .rx_we(rx_we),
        .rx_widx(rx_widx), .rx_wdata(rx_wdata), .tx_ridx(tx_ridx), .tx_rdata(tx_rdata),
        .rx_idx_q(rx_idx_q), .rx_seq_q(rx_seq_q), .tx_idx_q(tx_idx_q), .tx_seq_q(tx_seq_q));
    hfcw_chk u_hfcw_chk (.hclk(hclk), .hresetn(hresetn), .cmd(u_hfcw_if.cmd), .cmd_seq(u_hfcw_if.cmd_seq),
        .rate(u_hfcw_if.rate), .rx_slice(u_hfcw_if.rx_slice));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [383:0] exp, input logic [383:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // waits for hready; a stuck slave ends the run
    task automatic wt;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        rd = hrdata;
        if (hresp !== 1'b0) chk("hresp", 384'h0, {383'h0, hresp});
    endtask
    // distinct byte per position, so any byte order slip shows
    function automatic logic [383:0] mkw(input logic [7:0] i, input logic [7:0] f);
        logic [383:0] w;
        for (int k = 0; k < 48; k++) w[383-8*k -: 8] = 8'(k * 5) ^ i ^ f;
        return w;
    endfunction
    function automatic logic [31:0] exp_slice(input logic [383:0] w, input int r, input int s);
        logic [31:0] v;
        v = 32'h00000000;
        for (int b = 0; b < 4; b++)
            if (4 * s + b < POP[r]) v[31-8*b -: 8] = w[383-8*(4*s+b) -: 8];
        return v;
    endfunction
    initial begin
        {hresetn, hsel, hwrite, rx_we} = 4'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        rx_widx = 8'h00;
        tx_ridx = 8'h00;
        rx_wdata = 384'h0;
        {bad_count, num_checks} = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // each entry written twice: the later content must win
        for (int i = 0; i < 8; i++) begin
            rx_we <= 1'b1;
            rx_widx <= 8'(16 + 64 * (i % 4));
            rx_wdata <= mkw(8'(16 + 64 * (i % 4)), (i < 4) ? 8'hFF : 8'h00);
            @(posedge hclk);
        end
        rx_we <= 1'b0;
        for (int r = 0; r < 11; r++) begin
            xfer(1'b1, hfcw_pkg::A_RATE, 32'(r));
            for (int i = 0; i < 4; i++) begin
                x = 8'(16 + 64 * i);
                for (int s = 0; s < 13; s++) begin
                    xfer(1'b1, hfcw_pkg::A_RX_SEL, {20'h0, 4'(s), x});
                    xfer(1'b0, hfcw_pkg::A_RX_DATA, 32'h0);
                    chk("rx_data", {352'h0, exp_slice(mkw(x, 8'h00), r, s)}, {352'h0, rd});
                end
                chk("rx_idx_q", {376'h0, x}, {376'h0, rx_idx_q});
                chk("rx_seq_q", 384'hC, {380'h0, rx_seq_q});
            end
        end
        xfer(1'b1, hfcw_pkg::A_RATE, 32'h3);
        xfer(1'b1, hfcw_pkg::A_TX_SEL, 32'h005);
        xfer(1'b1, hfcw_pkg::A_TX_DATA, 32'hA1B2C3D4);
        xfer(1'b1, hfcw_pkg::A_TX_SEL, 32'h105);
        xfer(1'b1, hfcw_pkg::A_TX_DATA, 32'hE5F60718);
        tx_ridx <= 8'h05;
        repeat (2) @(posedge hclk);
        chk("tx_word", {344'h0, 40'hA1B2C3D4E5}, {344'h0, tx_rdata[383 -: 40]});
        chk("tx_sel", 384'h105, {372'h0, tx_seq_q, tx_idx_q});
        xfer(1'b0, hfcw_pkg::A_STATUS, 32'h0);
        chk("reserved", 384'h0, {352'h0, rd});
        xfer(1'b0, hfcw_pkg::A_TX_DATA, 32'h0);
        chk("tx_data_read", 384'h0, {352'h0, rd});
        xfer(1'b0, hfcw_pkg::A_RATE, 32'h0);
        chk("rate", 384'h3, {352'h0, rd});
        summarize();
    end
endmodule // test_hyperframe_ctrl_word_access
`default_nettype wire
